// File: logic/kam_axi_master.sv
// Overview of operation
// - data bus matches controller width, 512
// - incrementing full-width bursts only
// - bursts as long as allowed
// - all write strobes always set
// - several transactions outstanding at once
// - single transaction ID
// - write address only with data ready
// - read address only with room reserved
// - one master port per memory controller
// - unused channel group may be dropped
// - primary clock required, secondary optional
// - external interfaces on primary clock only
// - crossings use proper synchronisers
// - wait for synthesizer lock before work
// - pipelined reset distributed as tree
// - reset control flops only
// - register boundary inputs and outputs (outputs are registered here; inputs feed logic directly)
// - die crossings flop to flop
module kam_axi_master
  import kam_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic synth_locked,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [ADDR_W-1:0] cmd_src_addr,
  input wire logic [ADDR_W-1:0] cmd_dst_addr,
  input wire logic [CMD_W-1:0] cmd_beats,
  output logic busy,
  output logic done,
  output logic error,
  output logic m_axi_arvalid,
  input wire logic m_axi_arready,
  output logic [ADDR_W-1:0] m_axi_araddr,
  output logic [7:0] m_axi_arlen,
  output logic [2:0] m_axi_arsize,
  output logic [1:0] m_axi_arburst,
  output logic [ID_W-1:0] m_axi_arid,
  input wire logic m_axi_rvalid,
  output logic m_axi_rready,
  input wire logic [DATA_W-1:0] m_axi_rdata,
  input wire logic [1:0] m_axi_rresp,
  input wire logic m_axi_rlast,
  input wire logic [ID_W-1:0] m_axi_rid,
  output logic m_axi_awvalid,
  input wire logic m_axi_awready,
  output logic [ADDR_W-1:0] m_axi_awaddr,
  output logic [7:0] m_axi_awlen,
  output logic [2:0] m_axi_awsize,
  output logic [1:0] m_axi_awburst,
  output logic [ID_W-1:0] m_axi_awid,
  output logic m_axi_wvalid,
  input wire logic m_axi_wready,
  output logic [DATA_W-1:0] m_axi_wdata,
  output logic [STRB_W-1:0] m_axi_wstrb,
  output logic m_axi_wlast,
  input wire logic m_axi_bvalid,
  output logic m_axi_bready,
  input wire logic [1:0] m_axi_bresp,
  input wire logic [ID_W-1:0] m_axi_bid
);

  logic [RST_STAGES-1:0] rst_pipe_reg;
  logic rst_ctl_reg;
  logic rst_buf_reg;
  logic lock_meta_reg;
  logic lock_sync_reg;
  kam_state_t state_reg;
  logic cmd_ready_reg;
  logic cmd_fire;
  logic busy_reg;
  logic done_reg;
  logic error_reg;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [CMD_W-1:0] rd_left_reg;
  logic [CMD_W-1:0] wr_left_reg;
  logic [4:0] reserved_reg;
  logic [4:0] avail_reg;
  logic [7:0] b_pending_reg;
  logic arvalid_reg;
  logic [ADDR_W-1:0] araddr_reg;
  logic [7:0] arlen_reg;
  logic awvalid_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0] awlen_reg;
  logic rready_reg;
  logic bready_reg;
  logic wvalid_reg;
  logic wlast_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [6:0] beat_cnt_reg;
  logic [6:0] lq_mem [LENQ_DEPTH];
  logic [LENQ_AW:0] lq_wr_reg;
  logic [LENQ_AW:0] lq_rd_reg;
  logic [LENQ_AW:0] lq_count;
  logic lq_empty;
  logic lq_full;
  logic [6:0] ar_beats;
  logic [6:0] aw_beats;
  logic ar_room;
  logic ar_issue;
  logic aw_issue;
  logic push_fire;
  logic w_load;
  logic w_last_beat;
  logic b_fire;
  logic all_done;

  kam_stream_if #(.WIDTH(DATA_W)) push_if ();
  kam_stream_if #(.WIDTH(DATA_W)) pop_if ();

  // beats for the next burst: longest that the page, buffer and length allow
  function automatic logic [6:0] burst_beats(input logic [ADDR_W-1:0] addr,
                                             input logic [CMD_W-1:0] left);
    logic [6:0] page;
    logic [6:0] lim;
    page = PAGE_BEATS - {1'b0, addr[PAGE_MSB:BEAT_SHIFT]};
    lim = (page < MAX_BURST) ? page : MAX_BURST;
    burst_beats = (left < {25'h0, lim}) ? left[6:0] : lim;
  endfunction

  // reset pipeline, then two branches for control and buffer
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      rst_pipe_reg <= '1;
    else
      rst_pipe_reg <= {rst_pipe_reg[RST_STAGES-2:0], 1'b0};
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rst_ctl_reg <= 1'b1;
      rst_buf_reg <= 1'b1;
    end
    else
    begin
      rst_ctl_reg <= rst_pipe_reg[RST_STAGES-1];
      rst_buf_reg <= rst_pipe_reg[RST_STAGES-1];
    end
  end

  // lock pin from the synthesizer domain, two flops
  always_ff @(posedge clock or posedge rst_ctl_reg)
  begin
    if (rst_ctl_reg)
    begin
      lock_meta_reg <= 1'b0;
      lock_sync_reg <= 1'b0;
    end
    else
    begin
      lock_meta_reg <= synth_locked;
      lock_sync_reg <= lock_meta_reg;
    end
  end

  assign cmd_fire = cmd_valid && cmd_ready_reg;

  // sequencing of one copy job
  always_ff @(posedge clock or posedge rst_ctl_reg)
  begin
    if (rst_ctl_reg)
      state_reg <= KAM_IDLE;
    else
    begin
      unique case (state_reg)
        KAM_IDLE:
          if (cmd_fire)
            state_reg <= (cmd_beats == '0) ? KAM_FINISH : KAM_RUN;
        KAM_RUN:
          if (all_done)
            state_reg <= KAM_FINISH;
        KAM_FINISH:
          state_reg <= KAM_IDLE;
      endcase
    end
  end

  // job handshake and status, all registered
  always_ff @(posedge clock or posedge rst_ctl_reg)
  begin
    if (rst_ctl_reg)
    begin
      cmd_ready_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      cmd_ready_reg <= (state_reg == KAM_IDLE) && !cmd_fire && lock_sync_reg;
      busy_reg <= cmd_fire || (state_reg == KAM_RUN);
      done_reg <= (state_reg == KAM_FINISH);
    end
  end

  // error is sticky for the job; a bad response in the start cycle still sets it
  always_ff @(posedge clock or posedge rst_ctl_reg)
  begin
    if (rst_ctl_reg)
      error_reg <= 1'b0;
    else if ((b_fire && (m_axi_bresp != AXI_RESP_OKAY)) ||
             (push_fire && (m_axi_rresp != AXI_RESP_OKAY)))
      error_reg <= 1'b1;
    else if (cmd_fire)
      error_reg <= 1'b0;
  end

  // read side: reserve buffer room for the whole burst before asking
  assign ar_beats = burst_beats(rd_addr_reg, rd_left_reg);
  assign ar_room = ({3'h0, reserved_reg} + {1'b0, ar_beats}) <= {3'h0, FIFO_DEPTH_CNT};
  assign ar_issue = (state_reg == KAM_RUN) && (rd_left_reg != '0) && ar_room &&
                    push_if.ready && (!arvalid_reg || m_axi_arready);

  always_ff @(posedge clock or posedge rst_ctl_reg)
  begin
    if (rst_ctl_reg)
      arvalid_reg <= 1'b0;
    else if (ar_issue)
      arvalid_reg <= 1'b1;
    else if (m_axi_arready)
      arvalid_reg <= 1'b0;
  end

  // read address datapath
  always_ff @(posedge clock)
  begin
    if (cmd_fire)
      rd_addr_reg <= cmd_src_addr;
    else if (ar_issue)
      rd_addr_reg <= rd_addr_reg + (ADDR_W'(ar_beats) << BEAT_SHIFT);
    if (ar_issue)
    begin
      araddr_reg <= rd_addr_reg;
      arlen_reg <= {1'b0, ar_beats - 7'h01};
    end
  end

  // read beats still to request, and buffer slots promised
  always_ff @(posedge clock or posedge rst_ctl_reg)
  begin
    if (rst_ctl_reg)
    begin
      rd_left_reg <= '0;
      reserved_reg <= '0;
    end
    else
    begin
      if (cmd_fire)
        rd_left_reg <= cmd_beats;
      else if (ar_issue)
        rd_left_reg <= rd_left_reg - CMD_W'(ar_beats);
      reserved_reg <= reserved_reg + (ar_issue ? ar_beats[4:0] : 5'h00) - {4'h0, w_load};
    end
  end

  // read data lands in the buffer; room was reserved so ready stays high
  assign push_if.valid = m_axi_rvalid && rready_reg;
  assign push_if.data = m_axi_rdata;
  assign push_fire = push_if.valid && push_if.ready;

  always_ff @(posedge clock or posedge rst_ctl_reg)
  begin
    if (rst_ctl_reg)
    begin
      rready_reg <= 1'b0;
      bready_reg <= 1'b0;
    end
    else
    begin
      rready_reg <= (state_reg == KAM_RUN);
      bready_reg <= (state_reg == KAM_RUN);
    end
  end

  // write side: claim buffered beats, so the burst never starves
  assign aw_beats = burst_beats(wr_addr_reg, wr_left_reg);
  assign aw_issue = (state_reg == KAM_RUN) && (wr_left_reg != '0) && !lq_full &&
                    ({2'h0, avail_reg} >= aw_beats) && (!awvalid_reg || m_axi_awready);

  always_ff @(posedge clock or posedge rst_ctl_reg)
  begin
    if (rst_ctl_reg)
      awvalid_reg <= 1'b0;
    else if (aw_issue)
      awvalid_reg <= 1'b1;
    else if (m_axi_awready)
      awvalid_reg <= 1'b0;
  end

  // write address datapath
  always_ff @(posedge clock)
  begin
    if (cmd_fire)
      wr_addr_reg <= cmd_dst_addr;
    else if (aw_issue)
      wr_addr_reg <= wr_addr_reg + (ADDR_W'(aw_beats) << BEAT_SHIFT);
    if (aw_issue)
    begin
      awaddr_reg <= wr_addr_reg;
      awlen_reg <= {1'b0, aw_beats - 7'h01};
      lq_mem[lq_wr_reg[LENQ_AW-1:0]] <= aw_beats;
    end
  end

  // write beats left, unclaimed buffered beats, responses owed
  always_ff @(posedge clock or posedge rst_ctl_reg)
  begin
    if (rst_ctl_reg)
    begin
      wr_left_reg <= '0;
      avail_reg <= '0;
      b_pending_reg <= '0;
    end
    else
    begin
      if (cmd_fire)
        wr_left_reg <= cmd_beats;
      else if (aw_issue)
        wr_left_reg <= wr_left_reg - CMD_W'(aw_beats);
      avail_reg <= avail_reg + {4'h0, push_fire} - (aw_issue ? aw_beats[4:0] : 5'h00);
      b_pending_reg <= b_pending_reg + {7'h00, aw_issue} - {7'h00, b_fire};
    end
  end

  // burst length queue feeding the beat counter
  assign lq_count = lq_wr_reg - lq_rd_reg;
  assign lq_empty = (lq_count == '0);
  assign lq_full = (lq_count == LENQ_FULL_CNT);

  always_ff @(posedge clock or posedge rst_ctl_reg)
  begin
    if (rst_ctl_reg)
    begin
      lq_wr_reg <= '0;
      lq_rd_reg <= '0;
      beat_cnt_reg <= '0;
    end
    else
    begin
      if (aw_issue)
        lq_wr_reg <= lq_wr_reg + {{LENQ_AW{1'b0}}, 1'b1};
      if (w_load)
      begin
        beat_cnt_reg <= w_last_beat ? 7'h00 : beat_cnt_reg + 7'h01;
        if (w_last_beat)
          lq_rd_reg <= lq_rd_reg + {{LENQ_AW{1'b0}}, 1'b1};
      end
    end
  end

  // output stage for write data: buffer word straight into a flop
  assign w_last_beat = ((beat_cnt_reg + 7'h01) == lq_mem[lq_rd_reg[LENQ_AW-1:0]]);
  assign w_load = pop_if.valid && !lq_empty && (!wvalid_reg || m_axi_wready);
  assign pop_if.ready = w_load;

  always_ff @(posedge clock or posedge rst_ctl_reg)
  begin
    if (rst_ctl_reg)
      wvalid_reg <= 1'b0;
    else if (w_load)
      wvalid_reg <= 1'b1;
    else if (m_axi_wready)
      wvalid_reg <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (w_load)
    begin
      wdata_reg <= pop_if.data;
      wlast_reg <= w_last_beat;
    end
  end

  assign b_fire = m_axi_bvalid && bready_reg;
  assign all_done = (rd_left_reg == '0) && (wr_left_reg == '0) && (b_pending_reg == '0) &&
                    lq_empty && !wvalid_reg && !awvalid_reg && !arvalid_reg;

  kam_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst_buf_reg),
    .push(push_if.snk),
    .pop(pop_if.src)
  );

  // boundary outputs; write bursts wait on buffered read data, reads on buffer room freed by writes
  assign cmd_ready = cmd_ready_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign error = error_reg;
  assign m_axi_arvalid = arvalid_reg;
  assign m_axi_araddr = araddr_reg;
  assign m_axi_arlen = arlen_reg;
  assign m_axi_arsize = AXI_SIZE_FULL;
  assign m_axi_arburst = AXI_BURST_INCR;
  assign m_axi_arid = AXI_ID;
  assign m_axi_rready = rready_reg;
  assign m_axi_awvalid = awvalid_reg;
  assign m_axi_awaddr = awaddr_reg;
  assign m_axi_awlen = awlen_reg;
  assign m_axi_awsize = AXI_SIZE_FULL;
  assign m_axi_awburst = AXI_BURST_INCR;
  assign m_axi_awid = AXI_ID;
  assign m_axi_wvalid = wvalid_reg;
  assign m_axi_wdata = wdata_reg;
  assign m_axi_wstrb = STRB_ALL;
  assign m_axi_wlast = wlast_reg;
  assign m_axi_bready = bready_reg;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst_ctl_reg);

  sequence ar_stalled;
    m_axi_arvalid && !m_axi_arready;
  endsequence

  sequence ar_held;
    m_axi_arvalid && $stable(m_axi_araddr) && $stable(m_axi_arlen);
  endsequence

  sequence w_start;
    w_load && (beat_cnt_reg == 7'h00);
  endsequence

  AST_AR_PAGE: assert property (
    m_axi_arvalid |-> ({2'h0, m_axi_araddr[PAGE_MSB:BEAT_SHIFT]} + m_axi_arlen) < 8'h40)
    else $error("read burst crosses 4 KB page");

  AST_AW_PAGE: assert property (
    m_axi_awvalid |-> ({2'h0, m_axi_awaddr[PAGE_MSB:BEAT_SHIFT]} + m_axi_awlen) < 8'h40)
    else $error("write burst crosses 4 KB page");

  AST_AR_HOLD: assert property (
    ar_stalled |=> ar_held)
    else $error("read address changed while stalled");

  AST_RESERVE_BOUND: assert property (
    reserved_reg <= FIFO_DEPTH_CNT)
    else $error("buffer over-reserved");

  AST_R_NO_STALL: assert property (
    m_axi_rvalid && (state_reg == KAM_RUN) |-> m_axi_rready && push_if.ready)
    else $error("read data back-pressured");

  AST_AW_COVERED: assert property (
    m_axi_wvalid && m_axi_wready && !m_axi_wlast |=> m_axi_wvalid)
    else $error("write burst starved of data");

  AST_STRB_FULL: assert property (
    m_axi_wvalid |-> (m_axi_wstrb == STRB_ALL) && (m_axi_awsize == AXI_SIZE_FULL))
    else $error("partial write strobe or narrow size");

  AST_WLAST_POS: assert property (
    (w_start and (lq_mem[lq_rd_reg[LENQ_AW-1:0]] == 7'h01)) |=> m_axi_wvalid && m_axi_wlast)
    else $error("single beat burst without last");

  AST_LOCK_GATE: assert property (
    !lock_sync_reg |=> !cmd_ready)
    else $error("command accepted before lock");

  AST_DONE_PULSE: assert property (
    (state_reg == KAM_FINISH) |=> done ##1 !done)
    else $error("done not a one cycle pulse");

  AST_RST_RELEASE: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(rst_ctl_reg) |-> $past(rst_pipe_reg[RST_STAGES-1], 1) == 1'b0)
    else $error("control reset released out of pipeline order");

endmodule

// File: logic/kam_pkg.sv
package kam_pkg;

  // bus geometry
  localparam int DATA_W = 512;
  localparam int STRB_W = DATA_W / 8;
  localparam int ADDR_W = 64;
  localparam int ID_W = 1;
  localparam int CMD_W = 32;

  // address fields: beat offset bits and the 4 KB page
  localparam int BEAT_SHIFT = 6;
  localparam int PAGE_MSB = 11;
  localparam logic [6:0] PAGE_BEATS = 7'h40;

  // data buffer depth; bursts are capped at half of it so that a read always
  // finds room while a write with a different page offset waits for its beats
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] FIFO_DEPTH_CNT = 5'h10;
  localparam logic [6:0] MAX_BURST = 7'h08;

  // queue of granted write burst lengths
  localparam int LENQ_DEPTH = 4;
  localparam int LENQ_AW = 2;
  localparam logic [LENQ_AW:0] LENQ_FULL_CNT = 3'h4;

  // reset pipeline length
  localparam int RST_STAGES = 3;

  // fixed AXI4 attributes
  localparam logic [2:0] AXI_SIZE_FULL = 3'h6;
  localparam logic [1:0] AXI_BURST_INCR = 2'h1;
  localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
  localparam logic [ID_W-1:0] AXI_ID = 1'h0;
  localparam logic [STRB_W-1:0] STRB_ALL = {STRB_W{1'b1}};

  // engine states
  typedef enum logic [2:0] {
    KAM_IDLE = 3'b001,
    KAM_RUN = 3'b010,
    KAM_FINISH = 3'b100
  } kam_state_t;

endpackage

// File: logic/kam_stream_if.sv
interface kam_stream_if #(
  parameter int WIDTH = 512
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: logic/kam_fifo.sv
module kam_fifo #(
  parameter int WIDTH = 512,
  parameter int DEPTH = 16
)
(
  input wire logic clock,
  input wire logic rst,
  kam_stream_if.snk push,
  kam_stream_if.src pop
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic full;
  logic empty;

  // pointers carry one wrap bit
  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign push.ready = !full;
  assign pop.valid = !empty;
  assign pop.data = mem[rd_ptr_reg[AW-1:0]];

  // storage is datapath, no reset
  always_ff @(posedge clock)
  begin
    if (push.valid && !full)
    begin
      mem[wr_ptr_reg[AW-1:0]] <= push.data;
    end
  end

  // write pointer
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      wr_ptr_reg <= '0;
    else if (push.valid && !full)
      wr_ptr_reg <= wr_ptr_reg + {{AW{1'b0}}, 1'b1};
  end

  // read pointer
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rd_ptr_reg <= '0;
    else if (pop.ready && !empty)
      rd_ptr_reg <= rd_ptr_reg + {{AW{1'b0}}, 1'b1};
  end
endmodule

// File: tb/kam_mem_model.sv
module kam_mem_model
  import kam_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic bad_resp,
  input wire logic m_axi_arvalid,
  output logic m_axi_arready,
  input wire logic [ADDR_W-1:0] m_axi_araddr,
  input wire logic [7:0] m_axi_arlen,
  output logic m_axi_rvalid,
  input wire logic m_axi_rready,
  output logic [DATA_W-1:0] m_axi_rdata,
  output logic [1:0] m_axi_rresp,
  output logic m_axi_rlast,
  output logic [ID_W-1:0] m_axi_rid,
  input wire logic m_axi_awvalid,
  output logic m_axi_awready,
  input wire logic [ADDR_W-1:0] m_axi_awaddr,
  input wire logic [7:0] m_axi_awlen,
  input wire logic m_axi_wvalid,
  output logic m_axi_wready,
  input wire logic [DATA_W-1:0] m_axi_wdata,
  input wire logic m_axi_wlast,
  output logic m_axi_bvalid,
  input wire logic m_axi_bready,
  output logic [1:0] m_axi_bresp,
  output logic [ID_W-1:0] m_axi_bid
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] SALT = 64'h5A5A_0000_0000_C3C3;
  typedef struct {logic [ADDR_W-1:0] a; int n; int t;} kam_req_t;
  kam_req_t rq[$];
  kam_req_t wq[$];
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  int cyc, rb, wb, bn, bad_last;
  assign m_axi_rid = AXI_ID;
  assign m_axi_bid = AXI_ID;
  // memory with a fixed read latency; slow mode stalls ready and read data
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rq.delete();
      wq.delete();
      {m_axi_arready, m_axi_awready, m_axi_wready} <= 3'h0;
      {m_axi_rvalid, m_axi_rlast, m_axi_bvalid} <= 3'h0;
      m_axi_rdata <= '0;
      cyc = 0;
      rb = 0;
      wb = 0;
      bn = 0;
    end
    else
    begin
      cyc++;
      if (m_axi_arvalid && m_axi_arready)
        rq.push_back('{m_axi_araddr, int'(m_axi_arlen), cyc});
      if (m_axi_awvalid && m_axi_awready)
        wq.push_back('{m_axi_awaddr, int'(m_axi_awlen), cyc});
      m_axi_arready <= !slow || cyc[0];
      m_axi_awready <= !slow || cyc[0];
      if (m_axi_wvalid && m_axi_wready)
      begin
        mem[wq[0].a + ADDR_W'(64 * wb)] = m_axi_wdata;
        if (m_axi_wlast !== (wb == wq[0].n))
          bad_last++;
        wb++;
        if (wb > wq[0].n)
        begin
          wq.pop_front();
          wb = 0;
          bn++;
        end
      end
      m_axi_wready <= wq.size() > 0 && (!slow || cyc[0]);
      // read beats come in order once the latency has passed
      if (!m_axi_rvalid || m_axi_rready)
      begin
        if (rq.size() > 0 && cyc - rq[0].t > 6 && (!slow || cyc % 3 != 0))
        begin
          m_axi_rvalid <= 1'b1;
          m_axi_rdata <= {8{(rq[0].a + ADDR_W'(64 * rb)) ^ SALT}};
          m_axi_rlast <= rb == rq[0].n;
          m_axi_rresp <= bad_resp ? 2'h2 : AXI_RESP_OKAY;
          rb++;
          if (rb > rq[0].n)
          begin
            rq.pop_front();
            rb = 0;
          end
        end
        else
        begin
          m_axi_rvalid <= 1'b0;
          m_axi_rdata <= ~m_axi_rdata;
        end
      end
      // one write response per completed burst
      if (!m_axi_bvalid || m_axi_bready)
      begin
        m_axi_bvalid <= bn > 0;
        m_axi_bresp <= bad_resp ? 2'h2 : AXI_RESP_OKAY;
        if (bn > 0)
          bn--;
      end
    end
  end
endmodule

// File: tb/kam_axi_master_test.sv
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

module kam_axi_master_test import kam_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] SALT = 64'h5A5A_0000_0000_C3C3;
  logic clock = 0, sys_rst = 1, synth_locked = 0, cmd_valid = 0, slow = 0, bad_resp = 0;
  logic [ADDR_W-1:0] cmd_src_addr = '0, cmd_dst_addr = '0, m_axi_araddr, m_axi_awaddr, ra, wa;
  logic [CMD_W-1:0] cmd_beats = '0;
  logic cmd_ready, busy, done, error, m_axi_arvalid, m_axi_arready, m_axi_rvalid;
  logic m_axi_rready, m_axi_rlast, m_axi_awvalid, m_axi_awready, m_axi_wvalid;
  logic m_axi_wready, m_axi_wlast, m_axi_bvalid, m_axi_bready, w_in;
  logic [7:0] m_axi_arlen, m_axi_awlen;
  logic [2:0] m_axi_arsize, m_axi_awsize;
  logic [1:0] m_axi_arburst, m_axi_awburst, m_axi_rresp, m_axi_bresp;
  logic [ID_W-1:0] m_axi_arid, m_axi_awid, m_axi_rid, m_axi_bid;
  logic [DATA_W-1:0] m_axi_rdata, m_axi_wdata;
  logic [STRB_W-1:0] m_axi_wstrb;
  int n_fail = 0, cmp_count = 0, outs, outs_max, n_ar, w_gap, rstall, rl, wl, k;

  kam_axi_master kam_axi_master_i (.*);
  kam_mem_model kam_mem_model_i (.*);

  always #12.5 clock = ~clock;

  // expected burst length from what is left, the buffer and the page end
  function automatic int blen(input logic [ADDR_W-1:0] a, input int left);
    int n;
    n = int'(PAGE_BEATS) - int'(a[PAGE_MSB:BEAT_SHIFT]);
    if (left < n)
      n = left;
    if (n > int'(MAX_BURST))
      n = int'(MAX_BURST);
    return n;
  endfunction

  // watches the address, read data and write data handshakes on the memory side; write responses are not watched
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      w_in = 0;
      outs = 0;
    end
    else
    begin
      if (m_axi_arvalid && m_axi_arready)
      begin
        k = blen(ra, rl);
        `CHK("araddr", ra, m_axi_araddr)
        `CHK("arlen", 8'(k - 1), m_axi_arlen)
        `CHK("arattr", {AXI_SIZE_FULL, AXI_BURST_INCR}, {m_axi_arsize, m_axi_arburst})
        `CHK("arid", AXI_ID, m_axi_arid)
        rl -= k;
        ra += ADDR_W'(64 * k);
        n_ar++;
        outs++;
      end
      if (m_axi_rvalid && m_axi_rready && m_axi_rlast)
        outs--;
      if (outs > outs_max)
        outs_max = outs;
      if (m_axi_rvalid && !m_axi_rready && busy)
        rstall++;
      if (m_axi_awvalid && m_axi_awready)
      begin
        k = blen(wa, wl);
        `CHK("awaddr", wa, m_axi_awaddr)
        `CHK("awlen", 8'(k - 1), m_axi_awlen)
        `CHK("awattr", {AXI_SIZE_FULL, AXI_BURST_INCR}, {m_axi_awsize, m_axi_awburst})
        `CHK("awid", AXI_ID, m_axi_awid)
        wl -= k;
        wa += ADDR_W'(64 * k);
      end
      if (w_in && !m_axi_wvalid)
        w_gap++;
      if (m_axi_wvalid && m_axi_wready)
      begin
        `CHK("wstrb", STRB_ALL, m_axi_wstrb)
        w_in = !m_axi_wlast;
      end
    end
  end

  // offers one copy job; ab > 0 returns ab cycles after the take
  task automatic job(input logic [ADDR_W-1:0] s, d, input int n, input logic e, input int ab);
    int i;
    logic [ADDR_W-1:0] o;
    ra = s;
    wa = d;
    rl = n;
    wl = n;
    outs_max = 0;
    n_ar = 0;
    w_gap = 0;
    rstall = 0;
    for (i = 0; i < 200 && cmd_ready !== 1'b1; i++)
      @(negedge clock);
    cmd_src_addr = s;
    cmd_dst_addr = d;
    cmd_beats = CMD_W'(n);
    cmd_valid = 1;
    @(negedge clock);
    cmd_valid = 0;
    `CHK("cmd_ready", 1'b0, cmd_ready)
    if (n > 0)
      `CHK("busy", 1'b1, busy)
    if (ab > 0)
    begin
      repeat (ab) @(negedge clock);
      return;
    end
    for (i = 0; i < 5000 && done !== 1'b1; i++)
      @(negedge clock);
    `CHK("done", 1'b1, done)
    `CHK("error", e, error)
    `CHK("read left", 0, rl)
    `CHK("write left", 0, wl)
    `CHK("wlast", 0, kam_mem_model_i.bad_last)
    `CHK("w gaps", 0, w_gap)
    `CHK("r stalls", 0, rstall)
    for (i = 0; i < n && !e; i++)
    begin
      o = ADDR_W'(64 * i);
      `CHK("copy", {8{(s + o) ^ SALT}}, kam_mem_model_i.mem[d + o])
    end
  endtask

  // quiet outputs in reset, no work before the lock
  task automatic t_lock();
    repeat (16) @(negedge clock);
    `CHK("rst outs", 5'h0, {cmd_ready, busy, done, m_axi_arvalid, m_axi_awvalid})
    sys_rst = 0;
    repeat (20) @(negedge clock);
    `CHK("no lock", 1'b0, cmd_ready)
    synth_locked = 1;
  endtask

  // page-crossing addresses and a long copy with pipelined reads
  task automatic t_long();
    job(64'h0000_0000_0000_1F80, 64'h0000_0000_0010_3FC0, 40, 1'b0, 0);
    `CHK("pipelined", 1'b1, outs_max > 1)
  endtask

  // an empty job finishes without any burst
  task automatic t_zero();
    job(64'h0000_0000_0000_5000, 64'h0000_0000_0050_0000, 0, 1'b0, 0);
    `CHK("no bursts", 0, n_ar)
  endtask

  // full-length burst against a stalling memory
  task automatic t_slow();
    slow = 1;
    job(64'h0000_0000_0000_2000, 64'h0000_0000_0020_0000, 16, 1'b0, 0);
    slow = 0;
  endtask

  // error responses are reported, then cleared by the next job
  task automatic t_err();
    bad_resp = 1;
    job(64'h0000_0000_0000_3000, 64'h0000_0000_0030_0000, 4, 1'b1, 0);
    bad_resp = 0;
    job(64'h0000_0000_0000_4000, 64'h0000_0000_0040_0000, 2, 1'b0, 0);
  endtask

  // reset in the middle of a job, then recovery
  task automatic t_mid_reset();
    job(64'h0000_0000_0000_6000, 64'h0000_0000_0060_0000, 64, 1'b0, 30);
    sys_rst = 1;
    @(negedge clock);
    `CHK("abort outs", 4'h0, {busy, m_axi_arvalid, m_axi_awvalid, m_axi_wvalid})
    repeat (15) @(negedge clock);
    sys_rst = 0;
    job(64'h0000_0000_0000_7000, 64'h0000_0000_0070_0000, 8, 1'b0, 0);
  endtask

  task automatic stop_test();
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard, well beyond the length of all jobs
  initial
  begin
    #2000000;
    n_fail++;
    stop_test();
  end

  initial
  begin
    t_lock();
    t_long();
    t_zero();
    t_slow();
    t_err();
    t_mid_reset();
    stop_test();
  end
endmodule
